// file: lsc_lcd_driver.sv
// Function
// - drive_scan_control resets to zero: key scan off, external division.
// - bits 5:4 choose external (00) or internal (01) resistance division.
// - bit 1 read-only, reads 1 during key scan slice, else 0.
// - bit 0 turns segment key scan off (0) or on (1).
// - key scan adds one extra slice per frame, except in static mode, driving key sources.
// - display_mode_control resets to zero: off, grounded, no boost, 4-slice.
// - display enable bit 7; when 0 all segments deselected.
// - bit 6 low grounds all pins; high gives deselect segments, common waveform.
// - bit 4 enables internal gate voltage boosting.
// - mode field decodes 4/3 at 1/3, 2/3 at 1/2, static; rest prohibited.
// - forty segment outputs and four common outputs.
// - up to eight segments double as key source outputs.
// - frame rate is LCD clock ticks divided by slice count.
`timescale 1ns/1ps
module lsc_lcd_driver
    import lsc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic [15:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_lcd_tick,
    input wire logic [LSC_SEGS*LSC_COMS-1:0] i_disp_data,
    input wire logic [LSC_KRET-1:0] i_key_return,
    output logic [7:0] o_rdata,
    output logic [LSC_SEGS-1:0] o_seg_sel,
    output logic [LSC_COMS-1:0] o_com_act,
    output logic [LSC_KEYS-1:0] o_key_src,
    output logic [LSC_KRET-1:0] o_key_state,
    output logic o_pins_ground,
    output logic o_ac_phase,
    output logic o_bias_half,
    output logic o_static,
    output logic o_gate_boost,
    output logic o_vgen_internal,
    output logic o_key_scan_flag
);
    logic [1:0] volt_method;
    logic key_scan_enable;
    logic display_enable;
    logic pin_output_control;
    logic gate_boost_enable;
    logic [2:0] disp_mode;
    logic [2:0] act_mode;
    logic act_key;
    logic [2:0] disp_slices;
    logic [2:0] next_slices;
    logic [2:0] slice;
    logic frame_end;
    logic key_slice;
    logic [2:0] key_idx;
    logic [LSC_KRET-1:0] kr_meta;
    logic [LSC_KRET-1:0] kr_sync;
    logic [LSC_SEGS-1:0] next_seg_sel;
    logic [LSC_COMS-1:0] next_com_act;
    logic [LSC_KEYS-1:0] next_key_src;
    logic wr_dsc;
    logic wr_dmc;

    assign wr_dsc = i_wr && (i_addr == LSC_ADDR_DRIVE_SCAN);
    assign wr_dmc = i_wr && (i_addr == LSC_ADDR_DISP_MODE);

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            volt_method <= LSC_DRIVE_SCAN_RST[LSC_VM_HI:LSC_VM_LO];
            key_scan_enable <= LSC_DRIVE_SCAN_RST[LSC_KEY_SCAN_ENABLE_BIT];
        end else if (wr_dsc) begin
            volt_method <= i_wdata[LSC_VM_HI:LSC_VM_LO];
            key_scan_enable <= i_wdata[LSC_KEY_SCAN_ENABLE_BIT];
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            display_enable <= LSC_DISP_MODE_RST[LSC_DON_BIT];
            pin_output_control <= LSC_DISP_MODE_RST[LSC_POC_BIT];
            gate_boost_enable <= LSC_DISP_MODE_RST[LSC_BOOST_BIT];
            disp_mode <= LSC_DISP_MODE_RST[LSC_MODE_HI:LSC_MODE_LO];
        end else if (wr_dmc) begin
            display_enable <= i_wdata[LSC_DON_BIT];
            pin_output_control <= i_wdata[LSC_POC_BIT];
            gate_boost_enable <= i_wdata[LSC_BOOST_BIT];
            disp_mode <= i_wdata[LSC_MODE_HI:LSC_MODE_LO];
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_rdata <= LSC_RDATA_NONE;
        end else if (i_rd) begin
            o_rdata <= LSC_RDATA_NONE;
            if (i_addr == LSC_ADDR_DRIVE_SCAN) begin
                o_rdata[LSC_VM_HI:LSC_VM_LO] <= volt_method;
                o_rdata[LSC_KSF_BIT] <= o_key_scan_flag;
                o_rdata[LSC_KEY_SCAN_ENABLE_BIT] <= key_scan_enable;
            end else if (i_addr == LSC_ADDR_DISP_MODE) begin
                o_rdata[LSC_DON_BIT] <= display_enable;
                o_rdata[LSC_POC_BIT] <= pin_output_control;
                o_rdata[LSC_BOOST_BIT] <= gate_boost_enable;
                o_rdata[LSC_MODE_HI:LSC_MODE_LO] <= disp_mode;
            end
        end
    end

    // prohibited codes fall back to the 4-slice timing
    always_comb begin
        unique case (act_mode)
            LSC_MODE_3S_3B: disp_slices = LSC_SLICES_3;
            LSC_MODE_2S_2B: disp_slices = LSC_SLICES_2;
            LSC_MODE_3S_2B: disp_slices = LSC_SLICES_3;
            LSC_MODE_STATIC: disp_slices = LSC_SLICES_1;
            default: disp_slices = LSC_SLICES_4;
        endcase
    end

    // key slice appended except in static mode
    assign next_slices = disp_slices
        + ((act_key && act_mode != LSC_MODE_STATIC) ? LSC_KEY_ONE : LSC_SLICE_ZERO);
    assign key_slice = act_key && (act_mode != LSC_MODE_STATIC) && (slice == disp_slices);

    lsc_slice_seq u_seq (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_tick(i_lcd_tick),
        .i_slices(next_slices),
        .o_slice(slice),
        .o_frame_end(frame_end)
    );

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            act_mode <= LSC_MODE_4S_3B;
            act_key <= 1'h0;
            o_ac_phase <= 1'h0;
            key_idx <= LSC_SLICE_ZERO;
        end else if (frame_end) begin
            act_mode <= disp_mode;
            act_key <= key_scan_enable;
            o_ac_phase <= ~o_ac_phase;
            if (act_key) begin
                key_idx <= key_idx + LSC_SLICE_ONE;
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            kr_meta <= '0;
            kr_sync <= '0;
            o_key_state <= '0;
        end else begin
            kr_meta <= i_key_return;
            kr_sync <= kr_meta;
            if (key_slice && frame_end) begin
                o_key_state <= kr_sync;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < LSC_SEGS; g++) begin : g_seg
            always_comb begin
                next_seg_sel[g] = pin_output_control && display_enable && !key_slice
                    && i_disp_data[g*LSC_COMS + slice[1:0]];
            end
        end
        for (g = 0; g < LSC_COMS; g++) begin : g_com
            always_comb begin
                next_com_act[g] = pin_output_control && !key_slice
                    && ((act_mode == LSC_MODE_STATIC) || (slice[1:0] == g));
            end
        end
        for (g = 0; g < LSC_KEYS; g++) begin : g_key
            always_comb begin
                next_key_src[g] = pin_output_control && key_slice && (key_idx == g);
            end
        end
    endgenerate

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_seg_sel <= '0;
            o_com_act <= '0;
            o_key_src <= '0;
            o_pins_ground <= 1'h1;
            o_key_scan_flag <= 1'h0;
        end else begin
            o_seg_sel <= next_seg_sel;
            o_com_act <= next_com_act;
            o_key_src <= next_key_src;
            o_pins_ground <= !pin_output_control;
            o_key_scan_flag <= key_slice;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_bias_half <= 1'h0;
            o_static <= 1'h0;
            o_gate_boost <= 1'h0;
            o_vgen_internal <= 1'h0;
        end else begin
            o_bias_half <= (act_mode == LSC_MODE_2S_2B) || (act_mode == LSC_MODE_3S_2B);
            o_static <= act_mode == LSC_MODE_STATIC;
            o_gate_boost <= gate_boost_enable;
            o_vgen_internal <= volt_method == LSC_VM_INTERNAL;
        end
    end

    sequence s_wr_dsc_key;
        wr_dsc && i_wdata[LSC_KEY_SCAN_ENABLE_BIT];
    endsequence
    sequence s_wr_boost;
        wr_dmc && i_wdata[LSC_BOOST_BIT];
    endsequence

    property p_reset_zero;
        @(posedge i_mclk) $rose(i_rst_n) |-> volt_method == LSC_VM_EXTERNAL && !key_scan_enable
            && disp_mode == LSC_MODE_4S_3B && !display_enable && !pin_output_control && !gate_boost_enable;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("registers not cleared by reset");

    property p_method_int;
        @(posedge i_mclk) disable iff (!i_rst_n)
            wr_dsc && i_wdata[LSC_VM_HI:LSC_VM_LO] == LSC_VM_INTERNAL |=> ##1 o_vgen_internal;
    endproperty
    a_method_int: assert property (p_method_int) else $error("internal division not selected");

    property p_flag_read;
        @(posedge i_mclk) disable iff (!i_rst_n)
            i_rd && i_addr == LSC_ADDR_DRIVE_SCAN |=> o_rdata[LSC_KSF_BIT] == $past(o_key_scan_flag);
    endproperty
    a_flag_read: assert property (p_flag_read) else $error("key scan flag read mismatch");

    property p_key_enable;
        @(posedge i_mclk) disable iff (!i_rst_n)
            s_wr_dsc_key |=> key_scan_enable;
    endproperty
    a_key_enable: assert property (p_key_enable) else $error("key scan enable not stored");

    property p_key_slice;
        @(posedge i_mclk) disable iff (!i_rst_n)
            o_key_scan_flag |-> $past(act_key) && o_com_act == '0 && o_seg_sel == '0;
    endproperty
    a_key_slice: assert property (p_key_slice) else $error("key slice without key scan or with display");

    property p_disp_off;
        @(posedge i_mclk) disable iff (!i_rst_n)
            !display_enable |=> o_seg_sel == '0;
    endproperty
    a_disp_off: assert property (p_disp_off) else $error("segment selected while display off");

    property p_ground;
        @(posedge i_mclk) disable iff (!i_rst_n)
            !pin_output_control |=> o_pins_ground && o_com_act == '0 && o_key_src == '0;
    endproperty
    a_ground: assert property (p_ground) else $error("pins not grounded");

    property p_boost;
        @(posedge i_mclk) disable iff (!i_rst_n)
            s_wr_boost ##1 !wr_dmc |=> o_gate_boost;
    endproperty
    a_boost: assert property (p_boost) else $error("gate boost not applied");

    property p_one_com;
        @(posedge i_mclk) disable iff (!i_rst_n)
            !o_static |-> $onehot0(o_com_act);
    endproperty
    a_one_com: assert property (p_one_com) else $error("more than one common active");

    property p_mode_frame;
        @(posedge i_mclk) disable iff (!i_rst_n)
            $changed(act_mode) |-> $past(frame_end);
    endproperty
    a_mode_frame: assert property (p_mode_frame) else $error("mode changed inside a frame");

    property p_slice_bound;
        @(posedge i_mclk) disable iff (!i_rst_n)
            slice < next_slices;
    endproperty
    a_slice_bound: assert property (p_slice_bound) else $error("slice index beyond frame");
endmodule

// file: lsc_lcd_driver_tb.sv
`timescale 1ns/1ps
module lsc_lcd_driver_tb;
    import lsc_pkg::*;
    logic clk = 1'h0;
    logic rst_n, wr_s, rd_s, tick;
    logic [15:0] addr;
    logic [7:0] wdata, rdata, ksrc;
    logic [159:0] dd;
    logic [5:0] kret, kstate;
    logic [39:0] seg;
    logic [3:0] com;
    logic gnd, ph_ac, half, stat, boost, vint, kflag;
    int miscompares = 0;
    int compares = 0;
    always #2 clk = ~clk;
    lsc_lcd_driver DUT (.i_mclk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr_s), .i_rd(rd_s), .i_lcd_tick(tick), .i_disp_data(dd), .i_key_return(kret),
        .o_rdata(rdata), .o_seg_sel(seg), .o_com_act(com), .o_key_src(ksrc), .o_key_state(kstate),
        .o_pins_ground(gnd), .o_ac_phase(ph_ac), .o_bias_half(half), .o_static(stat),
        .o_gate_boost(boost), .o_vgen_internal(vint), .o_key_scan_flag(kflag));
    lsc_panel PANEL (.i_mclk(clk), .i_key_src(ksrc), .o_key_return(kret));

    task automatic chk_pin(string n, logic [39:0] e, logic [39:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic chk_reg(logic [7:0] e);
        chk_pin("rdata", 40'(e), 40'(rdata));
    endtask
    task automatic wr(logic [15:0] a, logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr_s = 1'h1;
        @(negedge clk);
        wr_s = 1'h0;
        repeat (2) @(negedge clk);
    endtask
    task automatic rd(logic [15:0] a, logic [7:0] e);
        @(negedge clk);
        addr = a;
        rd_s = 1'h1;
        @(negedge clk);
        rd_s = 1'h0;
        @(negedge clk);
        chk_reg(e);
    endtask
    task automatic step();
        @(negedge clk);
        tick = 1'h1;
        @(negedge clk);
        tick = 1'h0;
        repeat (4) @(negedge clk);
    endtask
    task automatic to_frame();
        logic p;
        p = ph_ac;
        for (int i = 0; i < 8 && ph_ac === p; i++) step();
    endtask
    task automatic t_regs();
        chk_pin("gnd", 40'h1, 40'(gnd));
        chk_pin("com", 40'h0, 40'(com));
        rd(LSC_ADDR_DRIVE_SCAN, 8'h00);
        rd(LSC_ADDR_DISP_MODE, 8'h00);
        rd(16'hFFB7, 8'h00);
        wr(LSC_ADDR_DRIVE_SCAN, 8'h12);
        rd(LSC_ADDR_DRIVE_SCAN, 8'h10);
        chk_pin("vint", 40'h1, 40'(vint));
        wr(LSC_ADDR_DRIVE_SCAN, 8'h20);
        chk_pin("vint", 40'h0, 40'(vint));
        wr(LSC_ADDR_DRIVE_SCAN, 8'h10);
        chk_pin("vint", 40'h1, 40'(vint));
        wr(LSC_ADDR_DRIVE_SCAN, 8'h00);
        chk_pin("vint", 40'h0, 40'(vint));
        $display("test regs done");
    endtask
    task automatic t_mode(logic [2:0] m, int n);
        logic p;
        logic [39:0] es;
        wr(LSC_ADDR_DISP_MODE, {5'h1A, m});
        to_frame();
        chk_pin("static", 40'(m == LSC_MODE_STATIC), 40'(stat));
        chk_pin("half", 40'(m inside {LSC_MODE_2S_2B, LSC_MODE_3S_2B}), 40'(half));
        chk_pin("boost", 40'h1, 40'(boost));
        p = ph_ac;
        for (int s = 0; s < n; s++) begin
            for (int g = 0; g < LSC_SEGS; g++) es[g] = dd[g*4 + (n == 1 ? 0 : s)];
            chk_pin("com", n == 1 ? 40'hF : 40'(1 << s), 40'(com));
            chk_pin("seg", es, seg);
            step();
            chk_pin("frame", 40'(s == n - 1 ? !p : p), 40'(ph_ac));
        end
        $display("test mode %0d done", m);
    endtask
    task automatic t_off();
        wr(LSC_ADDR_DISP_MODE, 8'h40);
        rd(LSC_ADDR_DISP_MODE, 8'h40);
        step();
        chk_pin("seg", 40'h0, seg);
        chk_pin("gnd", 40'h0, 40'(gnd));
        chk_pin("boost", 40'h0, 40'(boost));
        wr(LSC_ADDR_DISP_MODE, 8'h00);
        chk_pin("gnd", 40'h1, 40'(gnd));
        $display("test off done");
    endtask
    task automatic t_key();
        logic p;
        int k;
        wr(LSC_ADDR_DISP_MODE, 8'hC2);
        to_frame();
        wr(LSC_ADDR_DRIVE_SCAN, 8'h01);
        to_frame();
        p = ph_ac;
        chk_pin("flag", 40'h0, 40'(kflag));
        step();
        step();
        chk_pin("frame", 40'(p), 40'(ph_ac));
        chk_pin("flag", 40'h1, 40'(kflag));
        chk_pin("com", 40'h0, 40'(com));
        chk_pin("src1hot", 40'h1, 40'($onehot(ksrc)));
        k = 0;
        for (int i = 0; i < LSC_KEYS; i++) if (ksrc[i]) k = i;
        rd(LSC_ADDR_DRIVE_SCAN, 8'h03);
        step();
        chk_pin("frame", 40'(!p), 40'(ph_ac));
        chk_pin("kstate", 40'(6'h3F ^ (6'h01 << (k % 6))), 40'(kstate));
        chk_pin("src", 40'h0, 40'(ksrc));
        chk_pin("com", 40'h1, 40'(com));
        step();
        step();
        chk_pin("src", 40'(8'h01 << ((k + 1) % LSC_KEYS)), 40'(ksrc));
        step();
        chk_pin("kstate", 40'(6'h3F ^ (6'h01 << ((k + 1) % 6))), 40'(kstate));
        wr(LSC_ADDR_DRIVE_SCAN, 8'h00);
        $display("test key done");
    endtask
    task automatic wrap_up();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        rst_n = 1'h0;
        wr_s = 1'h0;
        rd_s = 1'h0;
        tick = 1'h0;
        addr = 16'h0000;
        wdata = 8'h00;
        dd = {5{32'hC3A5_96E1}};
        repeat (8) @(negedge clk);
        rst_n = 1'h1;
        t_regs();
        for (int m = 0; m < 5; m++) t_mode(3'(m), m == 4 ? 1 : (m == 0 ? 4 : (m == 2 ? 2 : 3)));
        t_off();
        t_key();
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        wrap_up();
    end
endmodule

// file: lsc_panel.sv
`timescale 1ns/1ps
module lsc_panel
    import lsc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic [LSC_KEYS-1:0] i_key_src,
    output logic [LSC_KRET-1:0] o_key_return
);
    logic [LSC_KRET-1:0] idle;
    // undriven return lines wander between key slices
    always_ff @(posedge i_mclk) begin
        idle <= (idle === 6'h2A) ? 6'h15 : 6'h2A;
    end
    // one pressed key per source, pulling its return line low
    always_comb begin
        o_key_return = idle;
        for (int k = 0; k < LSC_KEYS; k++) begin
            if (i_key_src[k]) begin
                o_key_return = 6'h3F ^ (6'h01 << (k % 6));
            end
        end
    end
endmodule

// file: lsc_pkg.sv
package lsc_pkg;
    localparam int unsigned LSC_SEGS = 40;
    localparam int unsigned LSC_COMS = 4;
    localparam int unsigned LSC_KEYS = 8;
    localparam int unsigned LSC_KRET = 6;
    localparam int unsigned LSC_KEY_SEGMENT_OUTPUT_0 = 24;

    localparam logic [15:0] LSC_ADDR_DRIVE_SCAN = 16'hFFB0;
    localparam logic [15:0] LSC_ADDR_DISP_MODE = 16'hFFB1;
    localparam logic [7:0] LSC_DRIVE_SCAN_RST = 8'h00;
    localparam logic [7:0] LSC_DISP_MODE_RST = 8'h00;
    localparam logic [7:0] LSC_RDATA_NONE = 8'h00;

    // drive_scan_control fields
    localparam int unsigned LSC_VM_HI = 5;
    localparam int unsigned LSC_VM_LO = 4;
    localparam int unsigned LSC_KSF_BIT = 1;
    localparam int unsigned LSC_KEY_SCAN_ENABLE_BIT = 0;
    localparam logic [1:0] LSC_VM_EXTERNAL = 2'h0;
    localparam logic [1:0] LSC_VM_INTERNAL = 2'h1;

    // display_mode_control fields
    localparam int unsigned LSC_DON_BIT = 7;
    localparam int unsigned LSC_POC_BIT = 6;
    localparam int unsigned LSC_BOOST_BIT = 4;
    localparam int unsigned LSC_MODE_HI = 2;
    localparam int unsigned LSC_MODE_LO = 0;

    localparam logic [2:0] LSC_MODE_4S_3B = 3'h0;
    localparam logic [2:0] LSC_MODE_3S_3B = 3'h1;
    localparam logic [2:0] LSC_MODE_2S_2B = 3'h2;
    localparam logic [2:0] LSC_MODE_3S_2B = 3'h3;
    localparam logic [2:0] LSC_MODE_STATIC = 3'h4;

    localparam logic [2:0] LSC_SLICES_1 = 3'h1;
    localparam logic [2:0] LSC_SLICES_2 = 3'h2;
    localparam logic [2:0] LSC_SLICES_3 = 3'h3;
    localparam logic [2:0] LSC_SLICES_4 = 3'h4;
    localparam logic [2:0] LSC_SLICE_ONE = 3'h1;
    localparam logic [2:0] LSC_SLICE_ZERO = 3'h0;
    localparam logic [2:0] LSC_KEY_ONE = 3'h1;
endpackage

// file: lsc_slice_seq.sv
`timescale 1ns/1ps
module lsc_slice_seq
    import lsc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_tick,
    input wire logic [2:0] i_slices,
    output logic [2:0] o_slice,
    output logic o_frame_end
);
    logic [2:0] slice;

    // frame ends on the tick of the last slice
    assign o_frame_end = i_tick && (slice >= (i_slices - LSC_SLICE_ONE));
    assign o_slice = slice;

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            slice <= LSC_SLICE_ZERO;
        end else if (o_frame_end) begin
            slice <= LSC_SLICE_ZERO;
        end else if (i_tick) begin
            slice <= slice + LSC_SLICE_ONE;
        end
    end
endmodule
